/* File: design/sfifo_mem.sv */
`timescale 1ns/10ps
module sfifo_mem #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 32
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] store [DEPTH];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      store[wr_addr] <= wr_data;
    end
  end

  // Registered read, follows writes to the slot one cycle later
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= store[rd_addr];
    end
  end

endmodule

/* File: design/sfifo_pkg.sv */
package sfifo_pkg;

  // Register map
  localparam logic [7:0] ADDR_OUT_P_HI = 8'h01;
  localparam logic [7:0] ADDR_OUT_P_MID = 8'h02;
  localparam logic [7:0] ADDR_OUT_P_LO = 8'h03;
  localparam logic [7:0] ADDR_OUT_T_HI = 8'h04;
  localparam logic [7:0] ADDR_OUT_T_LO = 8'h05;
  localparam logic [7:0] ADDR_FIFO_STATUS = 8'h0D;
  localparam logic [7:0] ADDR_FIFO_READ_PORT = 8'h0E;
  localparam logic [7:0] ADDR_FIFO_SETUP = 8'h0F;
  localparam logic [7:0] ADDR_OVERFLOW_DELAY = 8'h10;
  localparam logic [7:0] ADDR_SYSTEM_MODE = 8'h11;

  // Field layout and reset values
  localparam int SETUP_MODE_LSB = 6;
  localparam int SETUP_WMRK_MSB = 5;
  localparam logic [1:0] SETUP_MODE_RESET = 2'h0;
  localparam logic [5:0] SETUP_WMRK_RESET = 6'h00;
  localparam logic [7:0] DELAY_RESET = 8'h00;
  localparam logic [7:0] DELAY_MAX = 8'hFF;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [6:0] SYSMODE_PAD = 7'h00;

  // Samples
  localparam int SAMPLE_DEPTH = 32;
  localparam int SAMPLE_BYTES = 5;
  localparam logic [2:0] LAST_BYTE_IDX = 3'h4;

  // Link
  localparam logic [6:0] LINK_ADDR_DEFAULT = 7'h2A; // Arbitrary value
  localparam logic [3:0] LINK_BYTE_BITS = 4'h8;
  localparam int SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    SFIFO_MODE_OFF = 2'h0,
    SFIFO_MODE_CIRC = 2'h1,
    SFIFO_MODE_STOP = 2'h2,
    SFIFO_MODE_UNUSED = 2'h3
  } sfifo_mode_type;

  typedef enum logic [6:0] {
    SFIFO_LINK_IDLE = 7'h01,
    SFIFO_LINK_ADDR = 7'h02,
    SFIFO_LINK_ADDR_ACK = 7'h04,
    SFIFO_LINK_WR_BYTE = 7'h08,
    SFIFO_LINK_WR_ACK = 7'h10,
    SFIFO_LINK_RD_BYTE = 7'h20,
    SFIFO_LINK_RD_ACK = 7'h40
  } sfifo_link_state_type;

  typedef struct packed {
    logic [7:0] p_hi;
    logic [7:0] p_mid;
    logic [7:0] p_lo;
    logic [7:0] t_hi;
    logic [7:0] t_lo;
  } sfifo_sample_type;

endpackage

/* File: design/sfifo_sync.sv */
`timescale 1ns/10ps
module sfifo_sync import sfifo_pkg::*; #(
  parameter logic IDLE_LEVEL = 1'b1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic raw,
  output logic filtered
);

  typedef struct packed {
    logic [SYNC_STAGES-1:0] chain;
    logic out;
  } sfifo_sync_state_type;

  sfifo_sync_state_type q;
  sfifo_sync_state_type next_q;

  // Accept a change once the last two stages agree
  always_comb begin
    next_q = q;
    next_q.chain = {q.chain[SYNC_STAGES-2:0], raw};
    if (q.chain[SYNC_STAGES-1] == q.chain[SYNC_STAGES-2]) begin
      next_q.out = q.chain[SYNC_STAGES-1];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{chain: {SYNC_STAGES{IDLE_LEVEL}}, out: IDLE_LEVEL};
    end else begin
      q <= next_q;
    end
  end

  assign filtered = q.out;

endmodule

/* File: design/sfifo_top.sv */
`timescale 1ns/10ps
// Contract
// - Six-bit occupancy field reports zero to thirty-two stored samples.
// - Overflow flag set at thirty-two samples, held while overflowed.
// - Watermark flag rises when occupancy equals programmed watermark.
// - Watermark flag stays high while occupancy is above watermark.
// - Watermark value zero produces no watermark event.
// - Status read clears FIFO cause bit; flags follow their causes.
// - Mode 00 off, 01 circular, 10 stop when full, 11 unused.
// - Circular mode when full drops oldest sample, stores newest.
// - Off mode or standby-to-active flushes; off zeroes flags and count.
// - Passing the watermark never blocks sample writes.
// - Samples pushed at acquisition rate ticks.
// - Data port read gives oldest sample data and pops it.
// - Thirty-two samples, five bytes each: pressure three, temperature two.
// - Enabled FIFO also served at 01h; 02h to 05h read 00h.
// - Samples still accepted while host reads data port.
// - Eight-bit delay counts ticks after overflow, clears on last byte.
// - Mode register bit 0 shows standby or active, rest zero.
// - FIFO cause bit set on overflow or watermark equality event.
module sfifo_top import sfifo_pkg::*; #(
  parameter int DEPTH = SAMPLE_DEPTH,
  parameter logic [6:0] LINK_ADDR = LINK_ADDR_DEFAULT
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic sample_valid,
  input wire sfifo_sample_type sample_in,
  input wire logic system_active,
  output logic fifo_cause_bit
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

  generate
    if (DEPTH < 2 || DEPTH > 32 || (1 << PW) != DEPTH) begin : g_check
      $error("sfifo_top: DEPTH must be a power of two from 2 to 32");
    end
  endgenerate

  typedef struct packed {
    sfifo_link_state_type link;
    logic [3:0] bits;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic first;
    logic rw;
    logic m_ack;
    logic sda_oe;
    logic scl_d;
    logic sda_d;
    sfifo_mode_type mode;
    logic [5:0] watermark_level;
    logic [PW-1:0] head;
    logic [PW-1:0] tail;
    logic [CW-1:0] occupancy_count;
    logic [2:0] byte_idx;
    logic overflow_flag;
    logic watermark_hit_flag;
    logic cause;
    logic [7:0] delay_ticks;
    logic delay_run;
    logic active_d;
    sfifo_sample_type live;
  } sfifo_core_type;

  sfifo_core_type q;
  sfifo_core_type next_q;
  logic scl_s;
  logic sda_s;
  logic mem_wr;
  logic [PW-1:0] mem_wr_addr;
  logic [PW-1:0] mem_rd_addr;
  sfifo_sample_type mem_rd;

  sfifo_sync #(.IDLE_LEVEL(1'b1)) u_scl_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .raw(scl),
    .filtered(scl_s)
  );

  sfifo_sync #(.IDLE_LEVEL(1'b1)) u_sda_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .raw(sda_in),
    .filtered(sda_s)
  );

  sfifo_mem #(.WIDTH($bits(sfifo_sample_type)), .DEPTH(DEPTH)) u_mem (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr_en(mem_wr),
    .wr_addr(mem_wr_addr),
    .wr_data(sample_in),
    .rd_addr(mem_rd_addr),
    .rd_data(mem_rd)
  );

  always_comb begin
    logic scl_rise;
    logic scl_fall;
    logic do_load;
    logic rd_take;
    logic wr_take;
    logic [7:0] wr_byte;
    logic en;
    logic port_sel;
    logic [7:0] fifo_byte;
    logic [7:0] rd_value;
    logic status_read;
    logic pop;
    logic last;
    logic wrap;
    logic flush;
    logic [5:0] cnt6;
    logic [5:0] old6;
    logic event_hit;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    do_load = 1'b0;
    rd_take = 1'b0;
    wr_take = 1'b0;
    wr_byte = READ_ZERO;
    en = 1'b0;
    port_sel = 1'b0;
    fifo_byte = READ_ZERO;
    rd_value = READ_ZERO;
    status_read = 1'b0;
    pop = 1'b0;
    last = 1'b0;
    wrap = 1'b0;
    flush = 1'b0;
    cnt6 = 6'h00;
    old6 = 6'h00;
    event_hit = 1'b0;
    mem_wr = 1'b0;
    next_q = q;
    next_q.scl_d = scl_s;
    next_q.sda_d = sda_s;
    next_q.active_d = system_active;
    scl_rise = scl_s & ~q.scl_d;
    scl_fall = ~scl_s & q.scl_d;
    en = (q.mode == SFIFO_MODE_CIRC) || (q.mode == SFIFO_MODE_STOP);
    port_sel = (q.ptr == ADDR_FIFO_READ_PORT)
      || (en && q.ptr == ADDR_OUT_P_HI);
    if (q.occupancy_count != '0) begin
      case (q.byte_idx)
        3'h0: fifo_byte = mem_rd.p_hi;
        3'h1: fifo_byte = mem_rd.p_mid;
        3'h2: fifo_byte = mem_rd.p_lo;
        3'h3: fifo_byte = mem_rd.t_hi;
        default: fifo_byte = mem_rd.t_lo;
      endcase
    end
    case (q.ptr)
      ADDR_OUT_P_HI: rd_value = en ? fifo_byte : q.live.p_hi;
      ADDR_OUT_P_MID: rd_value = en ? READ_ZERO : q.live.p_mid;
      ADDR_OUT_P_LO: rd_value = en ? READ_ZERO : q.live.p_lo;
      ADDR_OUT_T_HI: rd_value = en ? READ_ZERO : q.live.t_hi;
      ADDR_OUT_T_LO: rd_value = en ? READ_ZERO : q.live.t_lo;
      ADDR_FIFO_STATUS: rd_value = {q.overflow_flag, q.watermark_hit_flag,
        6'(q.occupancy_count)};
      ADDR_FIFO_READ_PORT: rd_value = fifo_byte;
      ADDR_FIFO_SETUP: rd_value = {q.mode, q.watermark_level};
      ADDR_OVERFLOW_DELAY: rd_value = q.delay_ticks;
      ADDR_SYSTEM_MODE: rd_value = {SYSMODE_PAD, q.active_d};
      default: rd_value = READ_ZERO;
    endcase

    // Two-wire register link
    case (q.link)
      SFIFO_LINK_IDLE: begin
        next_q.sda_oe = 1'b0;
      end
      SFIFO_LINK_ADDR: begin
        if (scl_rise) begin
          next_q.shift = {q.shift[6:0], sda_s};
          next_q.bits = q.bits + 4'h1;
        end else if (scl_fall && q.bits == LINK_BYTE_BITS) begin
          next_q.bits = 4'h0;
          if (q.shift[7:1] == LINK_ADDR) begin
            next_q.rw = q.shift[0];
            next_q.sda_oe = 1'b1;
            next_q.link = SFIFO_LINK_ADDR_ACK;
          end else begin
            next_q.link = SFIFO_LINK_IDLE;
          end
        end
      end
      SFIFO_LINK_ADDR_ACK: begin
        if (scl_fall) begin
          if (q.rw) begin
            do_load = 1'b1;
            next_q.link = SFIFO_LINK_RD_BYTE;
          end else begin
            next_q.sda_oe = 1'b0;
            next_q.first = 1'b1;
            next_q.link = SFIFO_LINK_WR_BYTE;
          end
        end
      end
      SFIFO_LINK_WR_BYTE: begin
        if (scl_rise) begin
          next_q.shift = {q.shift[6:0], sda_s};
          next_q.bits = q.bits + 4'h1;
        end else if (scl_fall && q.bits == LINK_BYTE_BITS) begin
          next_q.bits = 4'h0;
          next_q.sda_oe = 1'b1;
          next_q.link = SFIFO_LINK_WR_ACK;
          next_q.first = 1'b0;
          if (q.first) begin
            next_q.ptr = q.shift;
          end else begin
            wr_take = 1'b1;
            wr_byte = q.shift;
            next_q.ptr = q.ptr + 8'h01;
          end
        end
      end
      SFIFO_LINK_WR_ACK: begin
        if (scl_fall) begin
          next_q.sda_oe = 1'b0;
          next_q.link = SFIFO_LINK_WR_BYTE;
        end
      end
      SFIFO_LINK_RD_BYTE: begin
        if (scl_fall) begin
          if (q.bits == LINK_BYTE_BITS) begin
            next_q.sda_oe = 1'b0;
            next_q.bits = 4'h0;
            next_q.link = SFIFO_LINK_RD_ACK;
          end else begin
            next_q.sda_oe = ~q.shift[7];
            next_q.shift = {q.shift[6:0], 1'b0};
            next_q.bits = q.bits + 4'h1;
          end
        end
      end
      SFIFO_LINK_RD_ACK: begin
        if (scl_rise) begin
          next_q.m_ack = ~sda_s;
        end else if (scl_fall) begin
          if (q.m_ack) begin
            do_load = 1'b1;
            next_q.link = SFIFO_LINK_RD_BYTE;
          end else begin
            next_q.link = SFIFO_LINK_IDLE;
          end
        end
      end
      default: begin
        next_q.sda_oe = 1'b0;
        next_q.link = SFIFO_LINK_IDLE;
      end
    endcase
    if (do_load) begin
      rd_take = 1'b1;
      next_q.sda_oe = ~rd_value[7];
      next_q.shift = {rd_value[6:0], 1'b0};
      next_q.bits = 4'h1;
      next_q.ptr = port_sel ? q.ptr : q.ptr + 8'h01;
      status_read = (q.ptr == ADDR_FIFO_STATUS);
    end
    if (q.scl_d && scl_s && q.sda_d && !sda_s) begin
      next_q.link = SFIFO_LINK_ADDR;
      next_q.bits = 4'h0;
      next_q.sda_oe = 1'b0;
    end else if (q.scl_d && scl_s && !q.sda_d && sda_s) begin
      next_q.link = SFIFO_LINK_IDLE;
      next_q.sda_oe = 1'b0;
    end

    // Setup register; direct switch between operating modes refused
    if (wr_take && q.ptr == ADDR_FIFO_SETUP) begin
      next_q.watermark_level = wr_byte[SETUP_WMRK_MSB:0];
      if (!(en && wr_byte[7:SETUP_MODE_LSB] != SFIFO_MODE_OFF
          && wr_byte[7:SETUP_MODE_LSB] != q.mode)) begin
        next_q.mode = sfifo_mode_type'(wr_byte[7:SETUP_MODE_LSB]);
      end
    end

    // Sample storage
    if (sample_valid) begin
      next_q.live = sample_in;
    end
    flush = !en || (system_active && !q.active_d);
    pop = rd_take && port_sel && q.occupancy_count != '0;
    if (pop) begin
      if (q.byte_idx == LAST_BYTE_IDX) begin
        next_q.byte_idx = 3'h0;
        next_q.head = q.head + 1'b1;
        next_q.occupancy_count = q.occupancy_count - 1'b1;
        last = (q.occupancy_count == CW'(1));
      end else begin
        next_q.byte_idx = q.byte_idx + 3'h1;
      end
    end
    if (sample_valid && !flush) begin
      if (next_q.occupancy_count != FULL_COUNT) begin
        mem_wr = 1'b1;
        next_q.tail = q.tail + 1'b1;
        next_q.occupancy_count = next_q.occupancy_count + 1'b1;
      end else if (q.mode == SFIFO_MODE_CIRC) begin
        mem_wr = 1'b1;
        wrap = 1'b1;
        next_q.tail = q.tail + 1'b1;
        next_q.head = next_q.head + 1'b1;
        next_q.byte_idx = 3'h0;
      end
    end
    if (flush) begin
      next_q.head = '0;
      next_q.tail = '0;
      next_q.occupancy_count = '0;
      next_q.byte_idx = 3'h0;
    end

    // Status flags and cause bit
    cnt6 = 6'(next_q.occupancy_count);
    old6 = 6'(q.occupancy_count);
    next_q.overflow_flag = !flush
      && next_q.occupancy_count == FULL_COUNT;
    next_q.watermark_hit_flag = !flush && q.watermark_level != 6'h00
      && cnt6 >= q.watermark_level;
    event_hit = (next_q.overflow_flag && !q.overflow_flag)
      || (!flush && q.watermark_level != 6'h00
      && cnt6 == q.watermark_level && old6 != q.watermark_level);
    next_q.cause = event_hit || (q.cause && !status_read);

    // Delay counter after overflow or wrap
    if (flush || last) begin
      next_q.delay_ticks = DELAY_RESET;
      next_q.delay_run = 1'b0;
    end else begin
      if (next_q.overflow_flag || wrap) begin
        next_q.delay_run = 1'b1;
      end
      if (sample_valid && q.delay_run && q.delay_ticks != DELAY_MAX) begin
        next_q.delay_ticks = q.delay_ticks + 8'h01;
      end
    end
  end

  assign mem_wr_addr = q.tail;
  assign mem_rd_addr = next_q.head;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.link <= SFIFO_LINK_IDLE;
      q.scl_d <= 1'b1;
      q.sda_d <= 1'b1;
      q.mode <= sfifo_mode_type'(SETUP_MODE_RESET);
      q.watermark_level <= SETUP_WMRK_RESET;
      q.delay_ticks <= DELAY_RESET;
    end else begin
      q <= next_q;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = q.sda_oe;
  assign fifo_cause_bit = q.cause;

endmodule

/* File: sim/sensor_sample_fifo_tb.sv */
`timescale 1ns/10ps
module sensor_sample_fifo_tb import sfifo_pkg::*; ;
  logic mclk = 1'b0;
  logic rst_n, sample_valid, system_active, scl, pull, sda;
  logic sda_out, sda_oe, fifo_cause_bit, run, ecause;
  sfifo_sample_type sample_in;
  int error_cnt, tests_run, bi;
  logic [39:0] mq [$];
  logic [39:0] live;
  logic [1:0] mode;
  logic [5:0] wm;
  logic [7:0] dly;
  logic [31:0] st = 32'h00015E8F;
  assign sda = !(sda_oe || pull);
  sfifo_top sfifo_top_i (.mclk(mclk), .rst_n(rst_n), .scl(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .sample_valid(sample_valid), .sample_in(sample_in),
    .system_active(system_active), .fifo_cause_bit(fifo_cause_bit));
  sfifo_host sfifo_host_i (.scl(scl), .pull(pull), .sda(sda));
  initial forever #5 mclk = !mclk;
  function automatic logic fifo_on();
    return mode == 2'h1 || mode == 2'h2;
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string n, input logic [7:0] e,
    input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cchk;
    repeat (4) @(posedge mclk);
    chk("cause", {7'h00, ecause}, {7'h00, fifo_cause_bit});
  endtask
  function automatic void flush();
    mq.delete();
    bi = 0;
    dly = 8'h00;
    run = 1'b0;
  endfunction
  task automatic push(input int n);
    repeat (n) begin
      st = lfsr(st);
      live = {st[7:0], st};
      @(posedge mclk);
      sample_valid <= 1'b1;
      sample_in <= {st[7:0], st};
      @(posedge mclk);
      sample_valid <= 1'b0;
      if (run && dly != 8'hFF) dly++;
      if (fifo_on() && mq.size() == SAMPLE_DEPTH) begin
        if (mode == 2'h1) begin
          void'(mq.pop_front());
          mq.push_back({st[7:0], st});
          bi = 0;
        end
      end else if (fifo_on()) begin
        mq.push_back({st[7:0], st});
        if (mq.size() == SAMPLE_DEPTH || mq.size() == wm) ecause = 1'b1;
      end
      if (mq.size() == SAMPLE_DEPTH) run = 1'b1;
    end
  endtask
  function automatic logic [7:0] mread(input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (a == ADDR_FIFO_STATUS) begin
      r = {fifo_on() && mq.size() == SAMPLE_DEPTH,
        wm != 0 && mq.size() >= wm, 6'(mq.size())};
      ecause = 1'b0;
    end else if (a == ADDR_FIFO_READ_PORT
        || (a == ADDR_OUT_P_HI && fifo_on())) begin
      if (mq.size() > 0) begin
        r = 8'(mq[0] >> (8 * (4 - bi)));
        bi++;
        if (bi == SAMPLE_BYTES) begin
          void'(mq.pop_front());
          bi = 0;
          if (wm != 0 && mq.size() == wm) ecause = 1'b1;
          if (mq.size() == 0) flush();
        end
      end
    end else if (a >= ADDR_OUT_P_HI && a <= ADDR_OUT_T_LO && !fifo_on()) begin
      r = 8'(live >> (8 * (5 - a)));
    end else if (a == ADDR_FIFO_SETUP) r = {mode, wm};
    else if (a == ADDR_OVERFLOW_DELAY) r = dly;
    else if (a == ADDR_SYSTEM_MODE) r = {SYSMODE_PAD, system_active};
    return r;
  endfunction
  task automatic rd_chk(input string n, input logic [7:0] a, input int k);
    sfifo_host_i.rd(a, k);
    for (int i = 0; i < k; i++) begin
      chk(n, mread(a), sfifo_host_i.rq[i]);
      if (a != ADDR_FIFO_READ_PORT
          && !(a == ADDR_OUT_P_HI && fifo_on())) a++;
    end
  endtask
  task automatic wr_m(input logic [7:0] d);
    sfifo_host_i.wr(ADDR_FIFO_SETUP, d);
    wm = d[5:0];
    if (!(fifo_on() && d[7:6] != 2'h0 && d[7:6] != mode)) mode = d[7:6];
    if (!fifo_on()) flush();
  endtask
  task automatic act(input logic v);
    @(posedge mclk);
    system_active <= v;
    if (v) flush();
    repeat (4) @(posedge mclk);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    error_cnt++;
    test_done();
  end
  initial begin
    rst_n = 1'b1;
    sample_valid = 1'b0;
    system_active = 1'b0;
    sample_in = 40'h0;
    mode = 2'h0;
    wm = 6'h00;
    ecause = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    flush();
    live = 40'h0;
    #1 rst_n = 1'b0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (10) @(posedge mclk);
    rd_chk("setup", ADDR_FIFO_SETUP, 3);
    rd_chk("status", ADDR_FIFO_STATUS, 1);
    rd_chk("data", ADDR_FIFO_READ_PORT, 2);
    act(1'b1);
    rd_chk("sysmode", ADDR_SYSTEM_MODE, 1);
    $display("test reset done");
    wr_m(8'h83);
    push(3);
    cchk();
    rd_chk("status", ADDR_FIFO_STATUS, 1);
    push(31);
    cchk();
    rd_chk("delay", ADDR_OVERFLOW_DELAY, 1);
    rd_chk("status", ADDR_FIFO_STATUS, 1);
    cchk();
    rd_chk("data", ADDR_FIFO_READ_PORT, 5);
    rd_chk("alias", ADDR_OUT_P_HI, 5);
    rd_chk("outputs", ADDR_OUT_P_MID, 4);
    rd_chk("status", ADDR_FIFO_STATUS, 1);
    wr_m(8'h43);
    rd_chk("setup", ADDR_FIFO_SETUP, 1);
    $display("test stop done");
    wr_m(8'h00);
    rd_chk("status", ADDR_FIFO_STATUS, 1);
    rd_chk("delay", ADDR_OVERFLOW_DELAY, 1);
    wr_m(8'hC0);
    push(2);
    rd_chk("status", ADDR_FIFO_STATUS, 1);
    rd_chk("live", ADDR_OUT_P_HI, 5);
    wr_m(8'h00);
    wr_m(8'h40);
    push(5);
    cchk();
    fork
      rd_chk("data", ADDR_FIFO_READ_PORT, 5);
      begin
        repeat (300) @(posedge mclk);
        push(1);
      end
    join
    push(30);
    cchk();
    rd_chk("status", ADDR_FIFO_STATUS, 1);
    rd_chk("data", ADDR_FIFO_READ_PORT, 5);
    $display("test circular done");
    act(1'b0);
    act(1'b1);
    rd_chk("status", ADDR_FIFO_STATUS, 1);
    $display("test standby done");
    test_done();
  end
endmodule
bind sfifo_top sfifo_monitor sfifo_monitor_i (.mclk(mclk), .rst_n(rst_n),
  .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .sample_valid(sample_valid), .sample_in(sample_in),
  .system_active(system_active), .fifo_cause_bit(fifo_cause_bit));

/* File: sim/sfifo_host.sv */
`timescale 1ns/10ps
module sfifo_host import sfifo_pkg::*; (
  output logic scl,
  output logic pull,
  input wire logic sda
);
  logic [7:0] rq [$];
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic bit_io(input logic b, output logic r);
    pull = !b;
    #31.25 scl = 1'b1;
    #31.25 r = sda;
    #31.25 scl = 1'b0;
    #31.25;
  endtask
  task automatic start;
    pull = 1'b0;
    #31.25 scl = 1'b1;
    #31.25 pull = 1'b1;
    #31.25 scl = 1'b0;
    #31.25;
  endtask
  task automatic stop;
    pull = 1'b1;
    #31.25 scl = 1'b1;
    #31.25 pull = 1'b0;
    #62.5;
  endtask
  task automatic tx(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start();
    tx({LINK_ADDR_DEFAULT, 1'b0});
    tx(a);
    tx(d);
    stop();
  endtask
  task automatic rd(input logic [7:0] a, input int n);
    logic [7:0] d;
    logic r;
    rq.delete();
    start();
    tx({LINK_ADDR_DEFAULT, 1'b0});
    tx(a);
    start();
    tx({LINK_ADDR_DEFAULT, 1'b1});
    for (int i = 0; i < n; i++) begin
      for (int j = 7; j >= 0; j--) bit_io(1'b1, d[j]);
      bit_io(i == n - 1, r);
      rq.push_back(d);
    end
    stop();
  endtask
endmodule

/* File: sim/sfifo_monitor.sv */
`timescale 1ns/10ps
module sfifo_monitor import sfifo_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic sample_valid,
  input wire sfifo_sample_type sample_in,
  input wire logic system_active,
  input wire logic fifo_cause_bit
);
  logic scl_d;
  logic [7:0] since;
  // Cycles since the last link clock fall
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d <= 1'b1;
      since <= 8'hFF;
    end else begin
      scl_d <= scl;
      if (scl_d && !scl) since <= 8'h00;
      else if (since != 8'hFF) since <= since + 8'h01;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_OE_NEAR_FALL: assert property ($changed(sda_oe) |-> since <= 8'h08)
    else $error("data pin drive moved away from a clock fall");
  AST_OE_SHORT: assert property (sda_oe |-> since <= 8'h14)
    else $error("data pin held low past one bit");
  AST_OUT_LOW: assert property (sda_out == 1'b0)
    else $error("data pin output value not low");
  AST_CAUSE_RISE: assert property ($rose(fifo_cause_bit) |->
    $past(sample_valid) || since <= 8'h10)
    else $error("cause bit rose without a fifo event");
  AST_CAUSE_FALL: assert property ($fell(fifo_cause_bit) |-> since <= 8'h10)
    else $error("cause bit cleared without a link access");
  AST_CAUSE_KEEP: assert property (
    fifo_cause_bit && since == 8'hFF |=> fifo_cause_bit)
    else $error("cause bit dropped while link idle");
  AST_RESET_QUIET: assert property (disable iff (1'b0)
    !rst_n |-> !sda_oe && !fifo_cause_bit)
    else $error("outputs active during reset");
  AST_OE_IDLE_START: assert property (
    scl && scl_d && since == 8'hFF |-> !sda_oe)
    else $error("data pin driven on an idle link");
endmodule
